// ==== core/ampv_params.svh ====
`ifndef AMPV_PARAMS_SVH
`define AMPV_PARAMS_SVH

// ==========================================================================
// Register offsets.
`define AMPV_OFS_DIG 8'h02
`define AMPV_OFS_VCFG 8'h03
`define AMPV_OFS_VOLL 8'h04
`define AMPV_OFS_VOLR 8'h05

// ==========================================================================
// Reset values and writable-bit masks.
`define AMPV_DIG_RST 8'h14
`define AMPV_VCFG_RST 8'h80
`define AMPV_VOL_RST 8'hCF
`define AMPV_DIG_WMASK 8'hBF
`define AMPV_VCFG_WMASK 8'h83

// ==========================================================================
// Field positions.
`define AMPV_HPF_BIT 7
`define AMPV_BOOST_HI 5
`define AMPV_BOOST_LO 4
`define AMPV_SPEED_BIT 3
`define AMPV_FMT_HI 2
`define AMPV_FADE_BIT 7
`define AMPV_MUTER_BIT 1
`define AMPV_MUTEL_BIT 0

// ==========================================================================
// Volume codes below this one mute the channel.
`define AMPV_VOL_MUTE_BELOW 8'h07

// ==========================================================================
// Timing: one fade step per nominal sample period.
`define AMPV_CLK_PERIOD_NS 20
`define AMPV_FADE_STEP_NS 20833
`define AMPV_FADE_STEP_CYC (`AMPV_FADE_STEP_NS / `AMPV_CLK_PERIOD_NS)

// Control port device address (arbitrary value).
`define AMPV_DEV_ADDR 7'h2A

`endif

// ==== core/ampv_pkg.sv ====
package ampv_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_WDATA = 3'b011,
		ST_WACK = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b110
	} ampv_state_type;

	typedef struct packed {
		logic highpass_skip;
		logic [1:0] boost;
		logic speed_range_select;
		logic [2:0] in_format;
	} ampv_path_cfg_type;

	typedef struct packed {
		logic [7:0] gain_code;
		logic soft_mute;
	} ampv_chan_type;

endpackage

// ==== core/ampv_fade.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ampv_params.svh"

module ampv_fade (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic step_i,
	input wire logic fade_en_i,
	input wire logic mute_i,
	input wire logic [7:0] vol_i,
	output ampv_pkg::ampv_chan_type chan_o
);

	logic [7:0] applied_q;
	logic [7:0] applied_d;
	logic [7:0] target;

	// A soft mute fades towards code zero, which sits below the mute threshold.
	assign target = mute_i ? 8'h00 : vol_i;

	always_comb begin
		applied_d = applied_q;
		if (!fade_en_i) begin
			applied_d = target;
		end else if (step_i && applied_q < target) begin
			applied_d = applied_q + 8'h01;
		end else if (step_i && applied_q > target) begin
			applied_d = applied_q - 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			applied_q <= `AMPV_VOL_RST;
		end else begin
			applied_q <= applied_d;
		end
	end

	assign chan_o.gain_code = applied_q;
	assign chan_o.soft_mute = applied_q < `AMPV_VOL_MUTE_BELOW;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_fade_one_step: assert property (
		(fade_en_i && step_i && applied_q != target) |=>
		(applied_q == $past(applied_q) + 8'h01) || (applied_q == $past(applied_q) - 8'h01))
		else $error("fade did not move by one code");

	a_mute_thresh: assert property (
		(applied_q == target) |-> chan_o.soft_mute == (mute_i || vol_i < 8'h07))
		else $error("mute threshold wrong");

	a_no_fade_jump: assert property (
		(!fade_en_i && mute_i) |=> applied_q == 8'h00 && chan_o.soft_mute)
		else $error("unfaded mute did not reach zero");

endmodule

`default_nettype wire

// ==== core/ampv_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ampv_params.svh"

// How it works
// - Bit 7 set bypasses high-pass filter.
// - Bits 5:4 add 0/6/12/18 dB boost.
// - Bit 3 selects single or double speed.
// - Bits 2:0 select serial input framing.
// - Volume config bit 7 enables fading.
// - Config bit 1 soft-mutes right channel.
// - Config bit 0 soft-mutes left channel.
// - Left code FF is +24 dB, 0.5 dB steps.
// - Left volume resets to CF, 0 dB.
// - Codes below 07 mute the channel.
// - Separate right volume register at 0x05.
// - Right volume shares left encoding and reset.
module ampv_regs #(
	parameter int unsigned FADE_STEP_CYC = `AMPV_FADE_STEP_CYC,
	parameter logic [6:0] DEV_ADDR = `AMPV_DEV_ADDR
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output ampv_pkg::ampv_path_cfg_type path_cfg_o,
	output ampv_pkg::ampv_chan_type [1:0] chan_o
);

	// ======================================================================
	// Reset release and pin synchronisers.
	logic rst_meta_q;
	logic rst_n;
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
	assign bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

	// ======================================================================
	// Two-wire control port.
	ampv_pkg::ampv_state_type state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] tx_q, tx_d;
	logic first_q, first_d;
	logic rw_q, rw_d;
	logic ack_ok_q, ack_ok_d;
	logic wr_stb;
	logic [7:0] rd_data;
	logic [7:0] dig_q, dig_d;
	logic [7:0] vcfg_q, vcfg_d;
	logic [7:0] voll_q, voll_d;
	logic [7:0] volr_q, volr_d;

	always_comb begin
		case (ptr_q)
			`AMPV_OFS_DIG: rd_data = dig_q;
			`AMPV_OFS_VCFG: rd_data = vcfg_q;
			`AMPV_OFS_VOLL: rd_data = voll_q;
			`AMPV_OFS_VOLR: rd_data = volr_q;
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		tx_d = tx_q;
		first_d = first_q;
		rw_d = rw_q;
		ack_ok_d = ack_ok_q;
		wr_stb = 1'b0;
		if (bus_start) begin
			state_d = ampv_pkg::ST_ADDR;
			cnt_d = 4'h0;
		end else if (bus_stop) begin
			state_d = ampv_pkg::ST_IDLE;
		end else begin
			case (state_q)
				ampv_pkg::ST_ADDR, ampv_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_s2_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == ampv_pkg::ST_WDATA) begin
							state_d = ampv_pkg::ST_WACK;
							first_d = 1'b0;
							if (first_q) begin
								ptr_d = shift_q;
							end else begin
								wr_stb = 1'b1;
								ptr_d = ptr_q + 8'h01;
							end
						end else if (shift_q[7:1] == DEV_ADDR) begin
							state_d = ampv_pkg::ST_AACK;
							rw_d = shift_q[0];
						end else begin
							state_d = ampv_pkg::ST_IDLE;
						end
					end
				end
				ampv_pkg::ST_AACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							state_d = ampv_pkg::ST_RDATA;
							tx_d = rd_data;
						end else begin
							state_d = ampv_pkg::ST_WDATA;
							first_d = 1'b1;
						end
					end
				end
				ampv_pkg::ST_WACK: begin
					if (scl_fall) begin
						state_d = ampv_pkg::ST_WDATA;
						cnt_d = 4'h0;
					end
				end
				ampv_pkg::ST_RDATA: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						state_d = ampv_pkg::ST_RACK;
						ptr_d = ptr_q + 8'h01;
					end else if (scl_fall) begin
						tx_d = {tx_q[6:0], 1'b0};
					end
				end
				ampv_pkg::ST_RACK: begin
					if (scl_rise) begin
						ack_ok_d = ~sda_s2_q;
					end else if (scl_fall && ack_ok_q) begin
						state_d = ampv_pkg::ST_RDATA;
						tx_d = rd_data;
						cnt_d = 4'h0;
					end else if (scl_fall) begin
						state_d = ampv_pkg::ST_IDLE;
					end
				end
				default: begin
					state_d = ampv_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ampv_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			tx_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			ack_ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			tx_q <= tx_d;
			first_q <= first_d;
			rw_q <= rw_d;
			ack_ok_q <= ack_ok_d;
		end
	end

	// The line is only ever pulled low; a high level comes from the pull-up.
	assign sda_o = 1'b0;
	assign sda_oe_o = (state_q == ampv_pkg::ST_AACK) || (state_q == ampv_pkg::ST_WACK) ||
		((state_q == ampv_pkg::ST_RDATA) && !tx_q[7]);

	// ======================================================================
	// Register bank.
	always_comb begin
		dig_d = dig_q;
		vcfg_d = vcfg_q;
		voll_d = voll_q;
		volr_d = volr_q;
		if (wr_stb) begin
			case (ptr_q)
				`AMPV_OFS_DIG: dig_d = shift_q & `AMPV_DIG_WMASK;
				`AMPV_OFS_VCFG: vcfg_d = shift_q & `AMPV_VCFG_WMASK;
				`AMPV_OFS_VOLL: voll_d = shift_q;
				`AMPV_OFS_VOLR: volr_d = shift_q;
				default: dig_d = dig_q;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dig_q <= `AMPV_DIG_RST;
			vcfg_q <= `AMPV_VCFG_RST;
			voll_q <= `AMPV_VOL_RST;
			volr_q <= `AMPV_VOL_RST;
		end else begin
			dig_q <= dig_d;
			vcfg_q <= vcfg_d;
			voll_q <= voll_d;
			volr_q <= volr_d;
		end
	end

	// The host is trusted to keep the format code at or below 101.
	assign path_cfg_o.highpass_skip = dig_q[`AMPV_HPF_BIT];
	assign path_cfg_o.boost = dig_q[`AMPV_BOOST_HI:`AMPV_BOOST_LO];
	assign path_cfg_o.speed_range_select = dig_q[`AMPV_SPEED_BIT];
	assign path_cfg_o.in_format = dig_q[`AMPV_FMT_HI:0];

	// ======================================================================
	// Fade step divider and per-channel volume ramps.
	logic [15:0] div_q, div_d;
	logic step_en;

	assign step_en = (div_q == 16'(FADE_STEP_CYC - 1));

	always_comb begin
		div_d = step_en ? 16'h0000 : div_q + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_d;
		end
	end

	logic [1:0] mute_bits;
	logic [1:0][7:0] vol_codes;
	assign mute_bits = {vcfg_q[`AMPV_MUTER_BIT], vcfg_q[`AMPV_MUTEL_BIT]};
	assign vol_codes = {volr_q, voll_q};

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		ampv_fade u_fade (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.step_i(step_en),
			.fade_en_i(vcfg_q[`AMPV_FADE_BIT]),
			.mute_i(mute_bits[ch]),
			.vol_i(vol_codes[ch]),
			.chan_o(chan_o[ch])
		);
	end

	// ======================================================================
	// Checks.
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_write(logic [7:0] ofs);
		wr_stb && ptr_q == ofs;
	endsequence

	a_hpf_write: assert property (
		s_write(8'h02) |=> path_cfg_o.highpass_skip == $past(shift_q[7]))
		else $error("high-pass skip not stored");

	a_boost_write: assert property (
		s_write(8'h02) |=> path_cfg_o.boost == $past(shift_q[5:4]))
		else $error("boost field not stored");

	a_speed_write: assert property (
		s_write(8'h02) |=> path_cfg_o.speed_range_select == $past(shift_q[3]))
		else $error("speed select not stored");

	a_format_write: assert property (
		s_write(8'h02) |=> path_cfg_o.in_format == $past(shift_q[2:0]))
		else $error("format field not stored");

	a_mute_bits: assert property (
		s_write(8'h03) |=> mute_bits == $past(shift_q[1:0]) && vcfg_q[7] == $past(shift_q[7]))
		else $error("volume config not stored");

	a_left_mute: assert property (
		(mute_bits[0] && !vcfg_q[7]) |=> chan_o[0].soft_mute)
		else $error("left mute missing");

	a_vol_write: assert property (
		s_write(8'h04) ##1 !wr_stb |-> voll_q == $past(shift_q, 2))
		else $error("left volume not stored");

	a_right_write: assert property (
		s_write(8'h05) |=> volr_q == $past(shift_q) && $stable(voll_q))
		else $error("right volume not independent");

	a_reset_vals: assert property (
		$rose(rst_n) |-> voll_q == 8'hCF && volr_q == 8'hCF && dig_q == 8'h14)
		else $error("reset values wrong");

	a_reserved_zero: assert property (
		dig_q[6] == 1'b0 && vcfg_q[6:2] == 5'h00)
		else $error("reserved bit set");

endmodule

`default_nettype wire

// ==== testbench/ampv_host.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Two-wire host model.
module ampv_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_oe_o
);
	// Every change lands just after a falling clock edge, and each clock phase of a bit lasts ten cycles; a start holds the clock high for twenty.
	// That keeps the pins well clear of the device's two-stage input synchronisers.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Data is set mid-low, so it only changes while the clock is low; it is sampled at the end of the high phase.
	task automatic bit_io(input logic b, output logic r);
		tick(4);
		sda_oe_o = ~b;
		tick(6);
		scl_o = 1'b1;
		tick(10);
		r = sda_i;
		scl_o = 1'b0;
	endtask

	task automatic start_c();
		tick(4);
		sda_oe_o = 1'b0;
		tick(6);
		scl_o = 1'b1;
		tick(10);
		sda_oe_o = 1'b1;
		tick(10);
		scl_o = 1'b0;
	endtask

	task automatic stop_c();
		tick(4);
		sda_oe_o = 1'b1;
		tick(6);
		scl_o = 1'b1;
		tick(10);
		sda_oe_o = 1'b0;
		tick(10);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, nack);
	endtask

	task automatic get_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

`default_nettype wire

// ==== testbench/audio_path_volume_control_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module audio_path_volume_control_regs_tb;
	localparam int STEP = 4;
	localparam logic [6:0] ADDR = 7'h35;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic sda;
	logic scl, host_oe, sda_o, sda_oe, ramp_on;
	ampv_pkg::ampv_path_cfg_type cfg;
	ampv_pkg::ampv_chan_type [1:0] chan;
	logic [7:0] m [256];
	logic [7:0] dq [$];
	logic [7:0] last;
	logic [8:0] steps;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;

	always #10 clk = ~clk;
	// The line is pulled up; it is low whenever either party pulls it.
	assign sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;

	ampv_regs #(.FADE_STEP_CYC(STEP), .DEV_ADDR(ADDR)) uut (.clk_i(clk), .rst_n_i(rst_n),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .path_cfg_o(cfg),
		.chan_o(chan));
	ampv_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic put(input logic [7:0] b, input logic nack_e);
		logic n;
		host.put_byte(b, n);
		chk({8'h00, n}, {8'h00, nack_e});
	endtask

	task automatic wr(input logic [7:0] p);
		logic [7:0] q;
		q = p;
		host.start_c();
		put({ADDR, 1'b0}, 1'b0);
		put(p, 1'b0);
		foreach (dq[i]) begin
			put(dq[i], 1'b0);
			case (q)
				8'h02: m[q] = dq[i] & 8'hbf;
				8'h03: m[q] = dq[i] & 8'h83;
				8'h04, 8'h05: m[q] = dq[i];
				default: ;
			endcase
			q++;
		end
		host.stop_c();
	endtask

	task automatic rd(input logic [7:0] p, input int n);
		logic [7:0] b, q;
		q = p;
		host.start_c();
		put({ADDR, 1'b0}, 1'b0);
		put(p, 1'b0);
		host.start_c();
		put({ADDR, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			host.get_byte(i == n - 1, b);
			chk({1'b0, b}, {1'b0, m[q]});
			q++;
		end
		host.stop_c();
	endtask

	task automatic outs();
		logic [7:0] g;
		chk({2'b00, cfg}, {2'b00, m[2][7], m[2][5:0]});
		for (int c = 0; c < 2; c++) begin
			g = m[3][c] ? 8'h00 : m[4 + c];
			chk(chan[c], {g, g < 8'h07});
		end
	endtask

	always @(negedge clk) begin
		if (ramp_on && chan[0].gain_code !== last) begin
			chk({1'b0, chan[0].gain_code}, {1'b0, last + 8'h01});
			last = chan[0].gain_code;
			steps++;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			results();
		end
	end

	// ==========================================================================
	// Main sequence.
	initial begin
		logic [7:0] r;
		logic [7:0] vt [6];
		vt = '{8'h00, 8'h06, 8'h07, 8'h08, 8'hfe, 8'hff};
		ramp_on = 1'b0;
		last = 8'h00;
		steps = 9'h000;
		m = '{default: 8'h00};
		m[2] = 8'h14;
		m[3] = 8'h80;
		m[4] = 8'hcf;
		m[5] = 8'hcf;
		r = 8'($urandom(32'h55e5_4041));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		outs();
		rd(8'h01, 6);
		host.start_c();
		put({ADDR ^ 7'h01, 1'b0}, 1'b1);
		host.stop_c();
		$display("test 1 done");
		for (int i = 0; i < 6; i++) begin
			r = 8'($urandom);
			dq = {};
			dq.push_back({r[7:6], 2'(i), r[3], 3'(i % 6)});
			dq.push_back(8'($urandom));
			dq.push_back(vt[i]);
			dq.push_back(8'($urandom));
			dq.push_back(8'($urandom));
			dq.push_back(8'($urandom));
			wr(8'h02);
			rd(8'h01, 7);
			outs();
		end
		$display("test 2 done");
		dq = '{8'h80};
		wr(8'h03);
		dq = '{8'h20};
		wr(8'h04);
		repeat (1100) @(negedge clk);
		last = chan[0].gain_code;
		steps = 9'h000;
		ramp_on = 1'b1;
		dq = '{8'h30};
		wr(8'h04);
		repeat (200) @(negedge clk);
		ramp_on = 1'b0;
		chk(steps, 9'h010);
		outs();
		$display("test 3 done");
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		m[2] = 8'h14;
		m[3] = 8'h80;
		m[4] = 8'hcf;
		m[5] = 8'hcf;
		outs();
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		rd(8'h02, 4);
		outs();
		$display("test 4 done");
		results();
	end
endmodule

`default_nettype wire
